/* File: inc/flash_self_write_pkg.sv */
// flash_self_write_pkg: constants and types for the self-programming controller.
// assumes a 50 MHz core clock and an 8-bit special-function register port.
package flash_self_write_pkg;

  // core clock and programming times
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned ERASE_TIME_US = 2000;
  localparam int unsigned WRITE_TIME_US = 2000;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 24;

  // geometry
  localparam int unsigned PTR_W = 22;
  localparam int unsigned PTR_MOVE_W = 21;
  localparam int unsigned HOLD_DEPTH = 8;
  localparam int unsigned HOLD_IDX_W = 3;
  localparam int unsigned ERASE_LSB = 6;
  localparam int unsigned WRITE_LSB = 3;

  // special-function register indices on the register port
  localparam logic [2:0] SFR_CTRL = 3'h0;
  localparam logic [2:0] SFR_UNLOCK = 3'h1;
  localparam logic [2:0] SFR_LATCH = 3'h2;
  localparam logic [2:0] SFR_PTR_L = 3'h3;
  localparam logic [2:0] SFR_PTR_H = 3'h4;
  localparam logic [2:0] SFR_PTR_U = 3'h5;

  // memory_access_control field positions
  localparam int unsigned BIT_MSEL = 7;
  localparam int unsigned BIT_CONFIG_SELECT = 6;
  localparam int unsigned BIT_FREE = 4;
  localparam int unsigned BIT_WERR = 3;
  localparam int unsigned BIT_WRITE_ENABLE_BIT = 2;
  localparam int unsigned BIT_WR = 1;
  localparam int unsigned BIT_RD = 0;

  // reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [21:0] PTR_RST = 22'h000000;
  localparam logic [7:0] HOLD_RST = 8'hff;

  // unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_GOT_FIRST = 2'b01,
    UL_ARMED = 2'b10
  } unlock_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_FLASH_WRITE = 3'b001,
    OP_FLASH_ERASE = 3'b010,
    OP_EE_WRITE = 3'b011,
    OP_CFG_WRITE = 3'b100
  } op_kind_t;

  typedef enum logic [1:0] {
    PTR_KEEP = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC = 2'b11
  } ptr_mode_t;

endpackage

/* File: rtl/prog_timer.sv */
// prog_timer: down-counter that times one self-timed programming operation.
// assumes load is only pulsed while idle; done is a one-cycle pulse at the end.
`timescale 1ns/10ps
module prog_timer #(
  parameter int unsigned W = 24
) (
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous, active high; aborts a running count
  input wire logic load, // one-cycle pulse: start counting
  input wire logic [W-1:0] cycles, // duration in clock cycles, at least 1
  output logic busy, // high while counting
  output logic done // one-cycle pulse when the count runs out
);

  logic [W-1:0] count_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else if (load && !busy_q) begin
      count_q <= cycles;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      count_q <= count_q - W'(1);
      if (count_q == W'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && (count_q == W'(1));
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

/* File: rtl/flash_self_write.sv */
// flash_self_write: program flash self-programming control seen from the core.
// assumes the core drives the sfr port and table strobes from ref_clk, and that
// the flash array answers a word read in the same cycle as flash_rd_en.
`timescale 1ns/10ps
module flash_self_write #(
  parameter int unsigned ERASE_CYCLES = flash_self_write_pkg::ERASE_CYCLES,
  parameter int unsigned WRITE_CYCLES = flash_self_write_pkg::WRITE_CYCLES
) (
  input wire logic ref_clk, // core clock, 50 MHz
  input wire logic reset, // device reset, synchronous, active high
  input wire logic por_reset, // power-on reset, synchronous, active high
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [2:0] sfr_sel, // register index
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata, // register read data, one cycle after sfr_rd
  input wire logic table_read_op, // table read strobe
  input wire logic table_write_op, // table write strobe
  input wire logic [1:0] table_ptr_mode, // pointer update for the table op
  output logic flash_rd_en, // array word read request
  output logic [20:0] flash_rd_addr, // array word address, bit 20 is config space
  input wire logic [15:0] flash_rd_data, // array word, valid in the same cycle as the request
  output logic flash_write_req, // pulse: program one 8-byte block
  output logic flash_erase_req, // pulse: erase one 64-byte block
  output logic config_space, // active operation targets configuration space
  output logic [18:0] write_blk_addr, // block to program
  output logic [15:0] erase_blk_addr, // block to erase
  output logic [63:0] prog_data, // holding registers, byte 0 in bits 7:0
  output logic ee_write_req, // pulse: eeprom write start
  output logic ee_read_req, // pulse: eeprom read
  output logic prog_active, // timed operation running
  output logic fetch_stall, // hold off instruction fetch
  output logic write_complete_irq_flag, // sticky completion flag
  input wire logic write_complete_clr // clear the completion flag
);

  localparam int unsigned TW = flash_self_write_pkg::TIMER_W;
  localparam int unsigned PW = flash_self_write_pkg::PTR_W;
  localparam int unsigned MW = flash_self_write_pkg::PTR_MOVE_W;

  flash_self_write_pkg::unlock_state_t ul_q;
  flash_self_write_pkg::op_kind_t op_q;
  flash_self_write_pkg::op_kind_t op_d;

  logic msel_q, config_select_q, free_q, werr_q, write_enable_bit_q, wr_q, rd_q;
  logic [7:0] latch_q;
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_eff;
  logic [7:0] hold_q [flash_self_write_pkg::HOLD_DEPTH];
  logic wr_ctrl, wr_unlock, start_ok, busy, op_done, timer_busy;
  logic rd_pend_q, rd_byte_q;
  logic [20:0] rd_addr_q;
  logic [7:0] rdata_q;
  logic wreq_q, ereq_q, eereq_q, cfg_q, wc_flag_q;
  logic [18:0] wblk_q;
  logic [15:0] eblk_q;
  logic [TW-1:0] timer_cycles;
  logic table_ok;

  assign wr_ctrl = sfr_wr && (sfr_sel == flash_self_write_pkg::SFR_CTRL);
  assign wr_unlock = sfr_wr && (sfr_sel == flash_self_write_pkg::SFR_UNLOCK);
  assign busy = (op_q != flash_self_write_pkg::OP_NONE);
  assign table_ok = !busy;

  // the start is only honoured as the write right after the key pair
  assign start_ok = wr_ctrl && sfr_wdata[flash_self_write_pkg::BIT_WR] && write_enable_bit_q
    && (ul_q == flash_self_write_pkg::UL_ARMED) && !busy;

  // unlock sequence tracker; the unlock register itself holds no data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ul_q <= flash_self_write_pkg::UL_IDLE;
    end else if (sfr_wr) begin
      case (ul_q)
        flash_self_write_pkg::UL_IDLE: begin
          if (wr_unlock && sfr_wdata == flash_self_write_pkg::KEY_FIRST) begin
            ul_q <= flash_self_write_pkg::UL_GOT_FIRST;
          end
        end
        flash_self_write_pkg::UL_GOT_FIRST: begin
          if (wr_unlock && sfr_wdata == flash_self_write_pkg::KEY_SECOND) begin
            ul_q <= flash_self_write_pkg::UL_ARMED;
          end else if (wr_unlock && sfr_wdata == flash_self_write_pkg::KEY_FIRST) begin
            ul_q <= flash_self_write_pkg::UL_GOT_FIRST;
          end else begin
            ul_q <= flash_self_write_pkg::UL_IDLE;
          end
        end
        // any register write consumes the armed state, start or not
        flash_self_write_pkg::UL_ARMED: ul_q <= flash_self_write_pkg::UL_IDLE;
        default: ul_q <= flash_self_write_pkg::UL_IDLE;
      endcase
    end
  end

  // target choice: config space first, then flash or eeprom; no bulk erase kind exists
  always_comb begin
    if (config_select_q) begin
      op_d = flash_self_write_pkg::OP_CFG_WRITE;
    end else if (msel_q && free_q) begin
      op_d = flash_self_write_pkg::OP_FLASH_ERASE;
    end else if (msel_q) begin
      op_d = flash_self_write_pkg::OP_FLASH_WRITE;
    end else begin
      op_d = flash_self_write_pkg::OP_EE_WRITE;
    end
  end

  assign timer_cycles = (op_d == flash_self_write_pkg::OP_FLASH_ERASE) ?
    TW'(ERASE_CYCLES) : TW'(WRITE_CYCLES);

  prog_timer #(
    .W(TW)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(start_ok),
    .cycles(timer_cycles),
    .busy(timer_busy),
    .done(op_done)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      op_q <= flash_self_write_pkg::OP_NONE;
    end else if (start_ok) begin
      op_q <= op_d;
    end else if (op_done) begin
      op_q <= flash_self_write_pkg::OP_NONE;
    end
  end

  // target selects survive a device reset so a failed write can be traced
  always_ff @(posedge ref_clk) begin
    if (por_reset) begin
      msel_q <= 1'b0;
      config_select_q <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      msel_q <= sfr_wdata[flash_self_write_pkg::BIT_MSEL];
      config_select_q <= sfr_wdata[flash_self_write_pkg::BIT_CONFIG_SELECT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      free_q <= 1'b0;
    end else if (op_done && op_q == flash_self_write_pkg::OP_FLASH_ERASE) begin
      free_q <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      free_q <= sfr_wdata[flash_self_write_pkg::BIT_FREE];
    end
  end

  // write-enable may drop mid-operation; only start_ok and the ctrl readback look at it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_enable_bit_q <= 1'b0;
    end else if (wr_ctrl) begin
      write_enable_bit_q <= sfr_wdata[flash_self_write_pkg::BIT_WRITE_ENABLE_BIT];
    end
  end

  // software can only set the start bits; writing zero does nothing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_q <= 1'b0;
    end else if (start_ok) begin
      wr_q <= 1'b1;
    end else if (op_done) begin
      wr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_q <= 1'b0;
    end else if (rd_q) begin
      rd_q <= 1'b0;
    // the select written in the same byte decides, so a single write cannot sneak a flash read
    end else if (wr_ctrl && sfr_wdata[flash_self_write_pkg::BIT_RD]
        && !sfr_wdata[flash_self_write_pkg::BIT_MSEL] && !busy) begin
      rd_q <= 1'b1;
    end
  end

  // error flag is held across device reset; the aborting reset itself sets it
  always_ff @(posedge ref_clk) begin
    if (por_reset) begin
      werr_q <= 1'b0;
    end else if (reset && busy) begin
      werr_q <= 1'b1;
    end else if (op_done) begin
      werr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wc_flag_q <= 1'b0;
    end else if (op_done) begin
      wc_flag_q <= 1'b1;
    end else if (write_complete_clr) begin
      wc_flag_q <= 1'b0;
    end
  end

  // start pulses and addresses captured at the start write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wreq_q <= 1'b0;
      ereq_q <= 1'b0;
      eereq_q <= 1'b0;
      cfg_q <= 1'b0;
      wblk_q <= '0;
      eblk_q <= '0;
    end else begin
      wreq_q <= start_ok && (op_d == flash_self_write_pkg::OP_FLASH_WRITE
        || op_d == flash_self_write_pkg::OP_CFG_WRITE);
      ereq_q <= start_ok && (op_d == flash_self_write_pkg::OP_FLASH_ERASE);
      eereq_q <= start_ok && (op_d == flash_self_write_pkg::OP_EE_WRITE);
      if (start_ok) begin
        cfg_q <= (op_d == flash_self_write_pkg::OP_CFG_WRITE);
        wblk_q <= ptr_q[PW-1:flash_self_write_pkg::WRITE_LSB];
        eblk_q <= ptr_q[PW-1:flash_self_write_pkg::ERASE_LSB];
      end
    end
  end

  // pointer moves touch only the low 21 bits; bit 21 selects config space
  always_comb begin
    ptr_eff = ptr_q;
    if (table_ptr_mode == flash_self_write_pkg::PTR_PRE_INC) begin
      ptr_eff = {ptr_q[PW-1], ptr_q[MW-1:0] + MW'(1)};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_q <= flash_self_write_pkg::PTR_RST;
    end else if ((table_read_op || table_write_op) && table_ok) begin
      case (table_ptr_mode)
        flash_self_write_pkg::PTR_POST_INC: ptr_q[MW-1:0] <= ptr_q[MW-1:0] + MW'(1);
        flash_self_write_pkg::PTR_POST_DEC: ptr_q[MW-1:0] <= ptr_q[MW-1:0] - MW'(1);
        flash_self_write_pkg::PTR_PRE_INC: ptr_q <= ptr_eff;
        default: ptr_q <= ptr_q;
      endcase
    end else if (sfr_wr && sfr_sel == flash_self_write_pkg::SFR_PTR_L) begin
      ptr_q[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_sel == flash_self_write_pkg::SFR_PTR_H) begin
      ptr_q[15:8] <= sfr_wdata;
    end else if (sfr_wr && sfr_sel == flash_self_write_pkg::SFR_PTR_U) begin
      ptr_q[PW-1:16] <= sfr_wdata[PW-17:0];
    end
  end

  // table read: word request, then pick one byte by pointer bit 0
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
      rd_byte_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_pend_q <= table_read_op && table_ok;
      if (table_read_op && table_ok) begin
        rd_byte_q <= ptr_eff[0];
        rd_addr_q <= ptr_eff[PW-1:1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_q <= flash_self_write_pkg::LATCH_RST;
    end else if (rd_pend_q) begin
      latch_q <= rd_byte_q ? flash_rd_data[15:8] : flash_rd_data[7:0];
    end else if (sfr_wr && sfr_sel == flash_self_write_pkg::SFR_LATCH) begin
      latch_q <= sfr_wdata;
    end
  end

  // holding registers: the latch lands here, never in the array directly
  genvar gi;
  generate
    for (gi = 0; gi < flash_self_write_pkg::HOLD_DEPTH; gi++) begin : g_hold
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          hold_q[gi] <= flash_self_write_pkg::HOLD_RST;
        end else if (table_write_op && table_ok
            && ptr_eff[flash_self_write_pkg::HOLD_IDX_W-1:0]
            == flash_self_write_pkg::HOLD_IDX_W'(gi)) begin
          hold_q[gi] <= latch_q;
        end
      end
      assign prog_data[gi*8 +: 8] = hold_q[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_sel)
        flash_self_write_pkg::SFR_CTRL: rdata_q <= {msel_q, config_select_q, 1'b0, free_q,
          werr_q, write_enable_bit_q, wr_q, rd_q};
        flash_self_write_pkg::SFR_UNLOCK: rdata_q <= 8'h00;
        flash_self_write_pkg::SFR_LATCH: rdata_q <= latch_q;
        flash_self_write_pkg::SFR_PTR_L: rdata_q <= ptr_q[7:0];
        flash_self_write_pkg::SFR_PTR_H: rdata_q <= ptr_q[15:8];
        flash_self_write_pkg::SFR_PTR_U: rdata_q <= {2'b00, ptr_q[PW-1:16]};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_q;
  assign flash_rd_en = rd_pend_q;
  assign flash_rd_addr = rd_addr_q;
  assign flash_write_req = wreq_q;
  assign flash_erase_req = ereq_q;
  assign config_space = cfg_q;
  assign write_blk_addr = wblk_q;
  assign erase_blk_addr = eblk_q;
  assign ee_write_req = eereq_q;
  assign ee_read_req = rd_q;
  assign prog_active = timer_busy;
  // eeprom writes run in the background; only program-space work stops fetch
  assign fetch_stall = busy && (op_q != flash_self_write_pkg::OP_EE_WRITE);
  assign write_complete_irq_flag = wc_flag_q;

endmodule

/* File: dv/flash_array_model.sv */
// flash_array_model: program array that answers word reads from the controller.
// assumes a read request is sampled on ref_clk and the data is used within two edges.
`timescale 1ns/10ps
module flash_array_model (
  input wire logic ref_clk, // core clock
  input wire logic rd_en, // word read request
  input wire logic [20:0] rd_addr, // word address
  output logic [15:0] rd_data // word answer
);
  logic en_q = 1'b0;
  logic [20:0] a_q = 21'h0;
  logic [15:0] junk_q = 16'h3c3c;
  logic [21:0] b;
  function automatic logic [7:0] fb(logic [21:0] x);
    return x[7:0] ^ x[15:8] ^ {2'h0, x[21:16]} ^ 8'ha5;
  endfunction
  always_ff @(posedge ref_clk) begin
    en_q <= rd_en;
    a_q <= rd_addr;
    junk_q <= junk_q + 16'h9e37;
  end
  // outside the answer window the lines move every cycle, so a late sample cannot match
  assign b = {(rd_en ? rd_addr : a_q), 1'b0};
  assign rd_data = (rd_en || en_q) ? {fb(b | 22'h1), fb(b)} : junk_q;
endmodule

/* File: dv/flash_self_write_properties.sv */
// flash_self_write_properties: port-level timing checks for the controller.
// assumes it is bound into flash_self_write and handed its cycle counts.
`timescale 1ns/10ps
module flash_self_write_properties #(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned WRITE_CYCLES = 10
) (
  input wire logic ref_clk, // core clock
  input wire logic reset, // sync reset
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [2:0] sfr_sel, // index
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic table_read_op, // table read
  input wire logic flash_rd_en, // array read
  input wire logic flash_write_req, // program pulse
  input wire logic flash_erase_req, // erase pulse
  input wire logic prog_active, // timer running
  input wire logic fetch_stall, // fetch hold
  input wire logic write_complete_irq_flag, // done flag
  input wire logic write_complete_clr // flag clear
);
  localparam int E_LO = ERASE_CYCLES - 2;
  localparam int E_HI = ERASE_CYCLES + 2;
  localparam int W_LO = WRITE_CYCLES - 2;
  localparam int W_HI = WRITE_CYCLES + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_stall_at_start: assert property ((flash_write_req || flash_erase_req) |->
    fetch_stall && prog_active) else $error("fetch not held at flash start");
  a_stall_when_idle: assert property ((!prog_active && !$past(prog_active)) |-> !fetch_stall)
    else $error("fetch held with no operation");
  a_erase_holds: assert property (flash_erase_req |-> fetch_stall[*8])
    else $error("erase stall too short");
  a_erase_ends: assert property (flash_erase_req |-> ##[E_LO:E_HI] !fetch_stall)
    else $error("erase not ended by timer");
  a_write_ends: assert property (flash_write_req |-> ##[W_LO:W_HI] !prog_active)
    else $error("write not ended by timer");
  a_unlock_reads_zero: assert property ((sfr_rd && sfr_sel == flash_self_write_pkg::SFR_UNLOCK)
    |=> sfr_rdata == 8'h00) else $error("unlock register returned data");
  a_start_needs_key: assert property ((flash_write_req || flash_erase_req) |->
    $past(sfr_wr && sfr_sel == flash_self_write_pkg::SFR_CTRL && sfr_wdata[1])
    && $past(sfr_wdata, 2) == flash_self_write_pkg::KEY_SECOND
    && $past(sfr_wdata, 3) == flash_self_write_pkg::KEY_FIRST) else $error("start without key");
  a_read_fetches: assert property ((table_read_op && !prog_active && !$past(prog_active))
    |=> flash_rd_en)
    else $error("table read did not fetch");
  a_read_one_word: assert property (flash_rd_en |=> !flash_rd_en)
    else $error("array read longer than one word");
  a_flag_on_done: assert property (($fell(prog_active) && !$past(reset))
    |-> ##[0:2] write_complete_irq_flag)
    else $error("completion flag not raised");
  a_flag_sticky: assert property ((write_complete_irq_flag && !write_complete_clr)
    |=> write_complete_irq_flag) else $error("completion flag dropped by itself");
endmodule
bind flash_self_write flash_self_write_properties #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)
) chk_u (.ref_clk(ref_clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .table_read_op(table_read_op), .flash_rd_en(flash_rd_en),
  .flash_write_req(flash_write_req), .flash_erase_req(flash_erase_req),
  .prog_active(prog_active), .fetch_stall(fetch_stall),
  .write_complete_irq_flag(write_complete_irq_flag),
  .write_complete_clr(write_complete_clr));

/* File: dv/program_flash_self_write_control_bench.sv */
// program_flash_self_write_control_bench: self-checking bench for flash_self_write.
// assumes the array model answers reads; the tasks here play the core.
`timescale 1ns/10ps
module program_flash_self_write_control_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic por_reset = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [2:0] sfr_sel = 3'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic table_read_op = 1'b0;
  logic table_write_op = 1'b0;
  logic [1:0] table_ptr_mode = 2'h0;
  logic write_complete_clr = 1'b0;
  logic [7:0] sfr_rdata;
  logic flash_rd_en, flash_write_req, flash_erase_req, config_space;
  logic ee_write_req, ee_read_req, prog_active, fetch_stall, write_complete_irq_flag;
  logic [20:0] flash_rd_addr;
  logic [15:0] flash_rd_data, erase_blk_addr;
  logic [18:0] write_blk_addr;
  logic [63:0] prog_data;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_fw = 0;
  int n_fe = 0;
  int n_ew = 0;
  int n_er = 0;
  logic [31:0] rs = 32'h35;
  logic [31:0] r;
  logic [21:0] p = 22'h0;
  logic [7:0] lat = 8'h00;
  logic [7:0] hold [8] = '{default: 8'hff};
  flash_self_write #(.ERASE_CYCLES(20), .WRITE_CYCLES(10)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .por_reset(por_reset), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .table_read_op(table_read_op), .table_write_op(table_write_op),
    .table_ptr_mode(table_ptr_mode), .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .flash_write_req(flash_write_req), .flash_erase_req(flash_erase_req),
    .config_space(config_space), .write_blk_addr(write_blk_addr),
    .erase_blk_addr(erase_blk_addr), .prog_data(prog_data), .ee_write_req(ee_write_req),
    .ee_read_req(ee_read_req), .prog_active(prog_active), .fetch_stall(fetch_stall),
    .write_complete_irq_flag(write_complete_irq_flag),
    .write_complete_clr(write_complete_clr));
  flash_array_model arr_u (.ref_clk(ref_clk), .rd_en(flash_rd_en),
    .rd_addr(flash_rd_addr), .rd_data(flash_rd_data));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (flash_write_req === 1'b1) n_fw++;
    if (flash_erase_req === 1'b1) n_fe++;
    if (ee_write_req === 1'b1) n_ew++;
    if (ee_read_req === 1'b1) n_er++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  function automatic logic [7:0] fb(logic [21:0] x);
    return x[7:0] ^ x[15:8] ^ {2'h0, x[21:16]} ^ 8'ha5;
  endfunction
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(logic [63:0] got, logic [63:0] exp, string w);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic tick(int k = 1);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // keep=1 holds the strobe so the next write lands on the very next edge
  task automatic wr(logic [2:0] s, logic [7:0] d, bit keep = 1'b0);
    sfr_wr = 1'b1;
    sfr_sel = s;
    sfr_wdata = d;
    tick();
    if (!keep) begin
      sfr_wr = 1'b0;
      tick();
    end
  endtask
  task automatic rd(logic [2:0] s, logic [7:0] e, string w);
    sfr_rd = 1'b1;
    sfr_sel = s;
    tick();
    sfr_rd = 1'b0;
    tick();
    chk(sfr_rdata, e, w);
  endtask
  task automatic start(logic [7:0] c);
    wr(flash_self_write_pkg::SFR_UNLOCK, 8'h55, 1'b1);
    wr(flash_self_write_pkg::SFR_UNLOCK, 8'haa, 1'b1);
    wr(flash_self_write_pkg::SFR_CTRL, c);
  endtask
  task automatic sp(logic [21:0] v);
    wr(flash_self_write_pkg::SFR_PTR_L, v[7:0]);
    wr(flash_self_write_pkg::SFR_PTR_H, v[15:8]);
    wr(flash_self_write_pkg::SFR_PTR_U, {2'h0, v[21:16]});
    p = v;
  endtask
  task automatic top(bit w, logic [1:0] m);
    logic [21:0] e;
    e = p;
    if (m == 2'h3) e[20:0] = p[20:0] + 21'h1;
    if (w) table_write_op = 1'b1;
    else table_read_op = 1'b1;
    table_ptr_mode = m;
    tick();
    table_write_op = 1'b0;
    table_read_op = 1'b0;
    tick(3);
    if (w) hold[e[2:0]] = lat;
    else lat = fb(e);
    if (m == 2'h1 || m == 2'h3) p[20:0] = p[20:0] + 21'h1;
    if (m == 2'h2) p[20:0] = p[20:0] - 21'h1;
  endtask
  task automatic idle();
    for (int k = 0; k < 60 && prog_active !== 1'b0; k++) tick();
    chk(prog_active, 1'b0, "op never ended");
    // start and row-erase bits drop one edge after the timer stops
    tick();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(3);
    reset = 1'b0;
    por_reset = 1'b0;
    rd(flash_self_write_pkg::SFR_CTRL, 8'h00, "ctrl reset");
    rd(flash_self_write_pkg::SFR_LATCH, 8'h00, "latch reset");
    wr(flash_self_write_pkg::SFR_UNLOCK, 8'h55);
    rd(flash_self_write_pkg::SFR_UNLOCK, 8'h00, "unlock read");
    rd(3'h7, 8'h00, "unmapped read");
    chk(prog_data, {8{8'hff}}, "holding reset");
    $display("reset values done");
    r = xs();
    sp({1'b0, r[20:0]});
    for (int i = 0; i < 8; i++) begin
      top(1'b0, 2'(i));
      rd(flash_self_write_pkg::SFR_LATCH, lat, "table read");
    end
    $display("table reads done");
    r = xs();
    sp({1'b0, r[20:0]});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      lat = r[7:0];
      wr(flash_self_write_pkg::SFR_LATCH, lat);
      top(1'b1, 2'h1);
      chk(prog_data, {hold[7], hold[6], hold[5], hold[4], hold[3], hold[2], hold[1], hold[0]},
        "holding bytes");
    end
    $display("table writes done");
    start(8'h82);
    rd(flash_self_write_pkg::SFR_CTRL, 8'h80, "start without enable");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h84);
    wr(flash_self_write_pkg::SFR_UNLOCK, 8'h55, 1'b1);
    wr(flash_self_write_pkg::SFR_UNLOCK, 8'haa, 1'b1);
    wr(flash_self_write_pkg::SFR_LATCH, lat, 1'b1);
    wr(flash_self_write_pkg::SFR_CTRL, 8'h86);
    rd(flash_self_write_pkg::SFR_CTRL, 8'h84, "broken key");
    chk(n_fw + n_fe, 0, "refused starts");
    $display("refusals done");
    start(8'h86);
    chk(n_fw, 1, "write pulse");
    chk(write_blk_addr, p[21:3], "write block");
    chk(fetch_stall, 1'b1, "write stall");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h80);
    rd(flash_self_write_pkg::SFR_CTRL, 8'h82, "busy ctrl");
    idle();
    rd(flash_self_write_pkg::SFR_CTRL, 8'h80, "write done ctrl");
    chk(write_complete_irq_flag, 1'b1, "done flag");
    write_complete_clr = 1'b1;
    tick();
    write_complete_clr = 1'b0;
    tick();
    chk(write_complete_irq_flag, 1'b0, "flag clear");
    $display("flash write done");
    r = xs();
    sp({1'b0, r[20:0]});
    wr(flash_self_write_pkg::SFR_CTRL, 8'h94);
    start(8'h96);
    chk(n_fe, 1, "erase pulse");
    chk(erase_blk_addr, p[21:6], "erase block");
    chk(fetch_stall, 1'b1, "erase stall");
    idle();
    rd(flash_self_write_pkg::SFR_CTRL, 8'h84, "erase clears row bit");
    $display("erase done");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h01);
    rd(flash_self_write_pkg::SFR_CTRL, 8'h00, "eeprom read");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h81);
    rd(flash_self_write_pkg::SFR_CTRL, 8'h80, "flash read start");
    chk(n_er, 1, "read pulses");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h44);
    start(8'h46);
    chk(config_space, 1'b1, "config target");
    idle();
    wr(flash_self_write_pkg::SFR_CTRL, 8'h04);
    start(8'h06);
    chk(fetch_stall, 1'b0, "eeprom no stall");
    idle();
    chk(n_ew, 1, "eeprom write");
    chk(n_fw, 2, "config write");
    $display("targets done");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h84);
    start(8'h86);
    tick(2);
    reset = 1'b1;
    tick();
    reset = 1'b0;
    rd(flash_self_write_pkg::SFR_CTRL, 8'h88, "reset abort");
    wr(flash_self_write_pkg::SFR_CTRL, 8'h84);
    start(8'h86);
    idle();
    rd(flash_self_write_pkg::SFR_CTRL, 8'h84, "error cleared");
    $display("abort done");
    conclude();
  end
endmodule
